// File: sac_conv_ctrl.v
// conversion control and serial interface of a 24-bit converter
// assumes the host drives cs_n, sclk and din as asynchronous pins and that
// the filter presents its wide signed output on filt_data at conversion end
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_conv_ctrl #(
    parameter [31:0] WAKE_CYC = `SAC_WAKE_CYC,
    parameter [31:0] DRDY_LEAD_CYC = `SAC_DRDY_LEAD_CYC,
    parameter [31:0] TIMEOUT_CYC = `SAC_TIMEOUT_CYC,
    parameter [31:0] CONV_BASE_CYC = `SAC_CONV_BASE_CYC,
    parameter FILT_W = 32
)(
    input wire clock,                     // 200 MHz block clock
    input wire srst,                      // synchronous reset, high
    input wire cs_n,                      // chip select pin, low active
    input wire sclk,                      // serial clock pin
    input wire din,                       // serial data in pin
    output wire serial_out_ready_n,       // data out / ready low pin
    output wire serial_out_oe,            // high while pin is driven
    output wire serial_out_pullup,        // weak pull-up enable
    input wire signed [FILT_W-1:0] filt_data, // filter output value
    output wire powered_up,               // analog part powered
    output wire conv_active,              // conversion running
    output wire [15:0] conv_cfg,          // settings of running conversion
    output wire [23:0] result_data,       // conversion result register
    output wire [15:0] cfg_word           // configuration register
);
    // ****************************************************************
    // states and helpers
    // ****************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAKE = 2'h1;
    localparam [1:0] ST_CONV = 2'h2;
    localparam signed [FILT_W-1:0] RES_MAXP = `SAC_RES_MAXP;
    localparam signed [FILT_W-1:0] RES_MINN = `SAC_RES_MINN;

    function [15:0] seq_word;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: seq_word = `SAC_SEQ0;
                3'h1: seq_word = `SAC_SEQ1;
                3'h2: seq_word = `SAC_SEQ2;
                3'h3: seq_word = `SAC_SEQ3;
                3'h4: seq_word = `SAC_SEQ4;
                default: seq_word = `SAC_SEQ5;
            endcase
        end
    endfunction

    // conversion length relative to the fastest rate
    function [7:0] rate_mult;
        input [2:0] dr;
        begin
            case (dr)
                3'h0: rate_mult = 8'hA0;
                3'h1: rate_mult = 8'h50;
                3'h2: rate_mult = 8'h28;
                3'h3: rate_mult = 8'h14;
                3'h4: rate_mult = 8'h0A;
                3'h5: rate_mult = 8'h04;
                3'h6: rate_mult = 8'h02;
                default: rate_mult = 8'h01;
            endcase
        end
    endfunction

    function [23:0] sat24;
        input signed [FILT_W-1:0] v;
        begin
            if (v > RES_MAXP)
                sat24 = 24'h7FFFFF;
            else if (v < RES_MINN)
                sat24 = 24'h800000;
            else
                sat24 = v[23:0];
        end
    endfunction

    // ****************************************************************
    // pin synchronisation and reset
    // ****************************************************************
    wire [2:0] pins_s;
    wire cs_n_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire din_s = pins_s[0];
    reg swrst_q;
    wire rst = srst | swrst_q;

    sac_sync #(.W(3), .RST_VAL(3'h4)) u_sync (
        .clock(clock),
        .srst(srst),
        .pin_in({cs_n, sclk, din}),
        .pin_s(pins_s)
    );

    // ****************************************************************
    // serial interface
    // ****************************************************************
    reg sclk_d_q;
    reg [5:0] rise_cnt_q;
    reg [5:0] fall_cnt_q;
    reg [3:0] wbit_q;
    reg [47:0] tx_q;
    reg [15:0] rx_q;
    reg [31:0] to_cnt_q;
    reg [2:0] rec_idx_q;
    reg dout_q;
    reg oe_q;
    reg pull_q;
    reg [15:0] cfg_q;
    reg [15:0] act_cfg_q;
    reg [23:0] result_q;
    reg new_data_q;
    reg [1:0] state_q;
    reg [31:0] tmr_q;

    wire sel = ~cs_n_s;
    wire sclk_rise = sel & sclk_s & ~sclk_d_q;
    wire sclk_fall = sel & ~sclk_s & sclk_d_q;
    wire xfer = (rise_cnt_q != 6'h00) || (fall_cnt_q != 6'h00);
    wire timeout = xfer & (to_cnt_q >= TIMEOUT_CYC - 32'h1);
    wire xfer_end = xfer & (cs_n_s | timeout);
    wire [15:0] rx_word = {rx_q[14:0], din_s};
    wire word_done = sclk_fall & (wbit_q == 4'hF);
    wire busy = (state_q != ST_IDLE);
    wire [15:0] readback = {~busy, cfg_q[14:0]};
    wire wr_ok = xfer_end && (fall_cnt_q >= `SAC_WORD_BITS) &&
        (rx_q != 16'h0000) && (rx_q[2:1] == `SAC_WR_KEY);
    wire start_req = wr_ok & rx_q[`SAC_CFG_START];
    wire xfer_start = sclk_rise & (rise_cnt_q == 6'h00);

    always @(posedge clock) begin
        if (rst) begin
            sclk_d_q <= 1'b0;
            rise_cnt_q <= 6'h00;
            fall_cnt_q <= 6'h00;
            tx_q <= 48'h000000000000;
            rx_q <= 16'h0000;
            to_cnt_q <= 32'h0;
        end else begin
            sclk_d_q <= sclk_s;
            if (cs_n_s || timeout) begin
                rise_cnt_q <= 6'h00;
                fall_cnt_q <= 6'h00;
                to_cnt_q <= 32'h0;
            end else begin
                if (sclk_s || !xfer)
                    to_cnt_q <= 32'h0;
                else
                    to_cnt_q <= to_cnt_q + 32'h1;
                if (sclk_rise) begin
                    if (rise_cnt_q != `SAC_XFER_BITS)
                        rise_cnt_q <= rise_cnt_q + 6'h01;
                    if (rise_cnt_q == 6'h00)
                        tx_q <= {result_q, 8'h00, readback};
                    else
                        tx_q <= {tx_q[46:0], 1'b0};
                end
                if (sclk_fall) begin
                    if (fall_cnt_q != `SAC_XFER_BITS)
                        fall_cnt_q <= fall_cnt_q + 6'h01;
                    rx_q <= rx_word;
                end
            end
        end
    end

    // word counter and reset word recognition run over the whole select
    always @(posedge clock) begin
        if (srst) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= word_done && !swrst_q && (rec_idx_q == 3'h5) &&
                (rx_word == seq_word(3'h5));
        end
    end

    always @(posedge clock) begin
        if (rst || cs_n_s) begin
            wbit_q <= 4'h0;
            rec_idx_q <= 3'h0;
        end else if (sclk_fall) begin
            wbit_q <= wbit_q + 4'h1;
            if (wbit_q == 4'hF) begin
                if (rx_word == seq_word(rec_idx_q))
                    rec_idx_q <= (rec_idx_q == 3'h5) ? 3'h0 :
                        rec_idx_q + 3'h1;
                else if (rx_word == seq_word(3'h0))
                    rec_idx_q <= 3'h1;
                else
                    rec_idx_q <= 3'h0;
            end
        end
    end

    // ****************************************************************
    // output pin
    // ****************************************************************
    always @(posedge clock) begin
        // pin stage resets with the pin synchronisers only, so the
        // reset words do not drop the drive while still selected
        if (srst) begin
            dout_q <= 1'b1;
            oe_q <= 1'b0;
            pull_q <= 1'b1;
        end else begin
            oe_q <= sel;
            pull_q <= cs_n_s & cfg_q[`SAC_CFG_PULLUP];
            if (!sel)
                dout_q <= 1'b1;
            else if (rise_cnt_q != 6'h00)
                dout_q <= tx_q[47];
            else
                dout_q <= ~new_data_q;
        end
    end

    assign serial_out_ready_n = dout_q;
    assign serial_out_oe = oe_q;
    assign serial_out_pullup = pull_q;

    // ****************************************************************
    // configuration register
    // ****************************************************************
    always @(posedge clock) begin
        if (rst)
            cfg_q <= `SAC_CFG_RESET;
        else if (wr_ok)
            cfg_q <= {1'b0, rx_q[14:1], 1'b1};
    end

    // ****************************************************************
    // conversion sequencer
    // ****************************************************************
    wire mode_single = cfg_q[`SAC_CFG_MODE];
    wire [2:0] act_dr = act_cfg_q[`SAC_CFG_DR_HI:`SAC_CFG_DR_LO];
    wire [31:0] conv_len = CONV_BASE_CYC * {24'h000000, rate_mult(act_dr)};
    wire conv_end = (state_q == ST_CONV) && (tmr_q == conv_len - 32'h1);
    wire lead_hit = (state_q == ST_CONV) && !mode_single &&
        (conv_len > DRDY_LEAD_CYC) &&
        (tmr_q == conv_len - DRDY_LEAD_CYC - 32'h1);

    always @(posedge clock) begin
        if (rst) begin
            state_q <= ST_IDLE;
            tmr_q <= 32'h0;
            act_cfg_q <= `SAC_CFG_RESET;
            result_q <= `SAC_RESULT_RESET;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    tmr_q <= 32'h0;
                    if (!mode_single || start_req)
                        state_q <= ST_WAKE;
                end
                ST_WAKE: begin
                    if (tmr_q >= WAKE_CYC - 32'h1) begin
                        tmr_q <= 32'h0;
                        act_cfg_q <= cfg_q;
                        state_q <= ST_CONV;
                    end else begin
                        tmr_q <= tmr_q + 32'h1;
                    end
                end
                ST_CONV: begin
                    if (conv_end) begin
                        result_q <= sat24(filt_data);
                        tmr_q <= 32'h0;
                        act_cfg_q <= cfg_q;
                        if (mode_single)
                            state_q <= ST_IDLE;
                    end else begin
                        tmr_q <= tmr_q + 32'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    tmr_q <= 32'h0;
                end
            endcase
        end
    end

    // new data flag: conversion end wins over a read or the early release
    always @(posedge clock) begin
        if (rst)
            new_data_q <= 1'b0;
        else if (conv_end)
            new_data_q <= 1'b1;
        else if (xfer_start || lead_hit)
            new_data_q <= 1'b0;
    end

    assign powered_up = busy;
    assign conv_active = (state_q == ST_CONV);
    assign conv_cfg = act_cfg_q;
    assign result_data = result_q;
    assign cfg_word = readback;
endmodule // sac_conv_ctrl

// File: sac_consts.vh
// constants for the converter control block: config field positions,
// reset values, reset word sequence and timing counts at a 200 MHz clock
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

`define SAC_CLK_MHZ 200
`define SAC_CFG_RESET 16'h058B
`define SAC_CFG_START 15
`define SAC_CFG_MODE 8
`define SAC_CFG_DR_HI 7
`define SAC_CFG_DR_LO 5
`define SAC_CFG_PULLUP 3
`define SAC_WR_KEY 2'b01
`define SAC_RESULT_RESET 24'h000000
`define SAC_RES_MAXP 8388607
`define SAC_RES_MINN (-8388608)
`define SAC_XFER_BITS 6'd48
`define SAC_WORD_BITS 6'd16

`define SAC_SEQ0 16'h8100
`define SAC_SEQ1 16'h0012
`define SAC_SEQ2 16'hACCA
`define SAC_SEQ3 16'h8100
`define SAC_SEQ4 16'h0014
`define SAC_SEQ5 16'h0002

// times in their own units, counts derived from the clock rate
`define SAC_T_WAKE_US 25
`define SAC_T_DRDY_LEAD_US 8
`define SAC_T_TIMEOUT_US 28000
`define SAC_T_CONV_1K_US 1000
`define SAC_WAKE_CYC (`SAC_T_WAKE_US * `SAC_CLK_MHZ)
`define SAC_DRDY_LEAD_CYC (`SAC_T_DRDY_LEAD_US * `SAC_CLK_MHZ)
`define SAC_TIMEOUT_CYC (`SAC_T_TIMEOUT_US * `SAC_CLK_MHZ)
`define SAC_CONV_BASE_CYC (`SAC_T_CONV_1K_US * `SAC_CLK_MHZ)

`endif

// File: sac_sync.v
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clock
`timescale 1ns/1ps
module sac_sync #(
    parameter W = 3,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)(
    input wire clock,          // block clock
    input wire srst,           // synchronous reset, active high
    input wire [W-1:0] pin_in, // asynchronous inputs
    output wire [W-1:0] pin_s  // synchronised copies
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clock) begin
        if (srst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_s = sync_q;
endmodule // sac_sync

// File: sac_conv_ctrl_monitor.sv
// checker for the converter control block, bound to its top module
// assumes the bench uses a wake count well inside 40 cycles
`timescale 1ns/1ps
module sac_conv_ctrl_mon #(
    parameter FILT_W = 32
)(
    input wire clock, // block clock
    input wire srst, // sync reset
    input wire cs_n, // select pin
    input wire sclk, // serial clock pin
    input wire din, // serial data pin
    input wire serial_out_ready_n, // shared output
    input wire serial_out_oe, // output driven
    input wire serial_out_pullup, // weak pull-up
    input wire signed [FILT_W-1:0] filt_data, // filter value
    input wire powered_up, // analog powered
    input wire conv_active, // converting
    input wire [15:0] conv_cfg, // running settings
    input wire [23:0] result_data, // result register
    input wire [15:0] cfg_word // config readback
);
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    function [23:0] sat24(input signed [FILT_W-1:0] v);
        if (v > 8388607)
            sat24 = 24'h7FFFFF;
        else if (v < -8388608)
            sat24 = 24'h800000;
        else
            sat24 = v[23:0];
    endfunction

    desel_release_a: assert property (cs_n [*5] |-> !serial_out_oe)
        else $error("pin driven while deselected");
    desel_high_a: assert property (cs_n [*5] |-> serial_out_ready_n)
        else $error("output low while deselected");
    sel_drive_a: assert property (!cs_n [*5] |-> serial_out_oe)
        else $error("pin not driven while selected");
    pullup_follow_a: assert property
        (cs_n [*6] |-> serial_out_pullup == cfg_word[3])
        else $error("pull-up not following its setting");
    sel_no_pullup_a: assert property
        (!cs_n [*5] |-> !serial_out_pullup)
        else $error("pull-up on while selected");
    start_flag_a: assert property (conv_active |-> !cfg_word[15])
        else $error("start flag reads idle during conversion");
    wake_delay_a: assert property
        ($rose(powered_up) |-> !conv_active [*8] ##[1:40] conv_active)
        else $error("conversion start not after wake-up");
    single_off_a: assert property
        ($fell(conv_active) && conv_cfg[8] |-> ##[0:4] !powered_up)
        else $error("no power-down after single conversion");
    result_update_a: assert property
        ($changed(result_data) && result_data != 24'h0 |->
         $past(conv_active) && (result_data == sat24($past(filt_data)) ||
         result_data == sat24($past(filt_data, 2))))
        else $error("result not a saturated filter value");
endmodule // sac_conv_ctrl_mon

bind sac_conv_ctrl sac_conv_ctrl_mon #(.FILT_W(FILT_W)) u_mon (
    .clock(clock), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .serial_out_ready_n(serial_out_ready_n), .serial_out_oe(serial_out_oe),
    .serial_out_pullup(serial_out_pullup), .filt_data(filt_data),
    .powered_up(powered_up), .conv_active(conv_active),
    .conv_cfg(conv_cfg), .result_data(result_data), .cfg_word(cfg_word));

// File: sac_host_model.sv
// host serial master model driving select, clock and data pins
// assumes the bench resolves the shared output onto pin
`timescale 1ns/1ps
module sac_host_model #(
    parameter HALF_NS = 24
)(
    output reg cs_n, // select, low active
    output reg sclk, // serial clock, idle low
    output reg din, // data to device
    input wire pin // resolved shared output
);
    // ****************************************
    // transfer tasks
    // ****************************************
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end

    task sel(output reg rdy_n);
        begin
            cs_n = 1'b0;
            #(2 * HALF_NS);
            rdy_n = pin;
        end
    endtask

    task desel;
        begin
            cs_n = 1'b1;
            #(2 * HALF_NS);
        end
    endtask

    // bits n-1..0 of tx go out msb first; the host picks the length
    task xfer(input integer n, input [47:0] tx, output reg [47:0] rx);
        integer i;
        begin
            rx = 48'h0;
            for (i = n - 1; i >= 0; i = i - 1) begin
                din = tx[i];
                sclk = 1'b1;
                #HALF_NS;
                rx = {rx[46:0], pin};
                sclk = 1'b0;
                #HALF_NS;
            end
        end
    endtask
endmodule // sac_host_model

// File: sac_conv_ctrl_test.sv
// bench for the converter control block with a host model on the link
// assumes the checker binds itself; counts are shortened by parameters
`timescale 1ns/1ps
module sac_conv_ctrl_test;
    localparam [127:0] FV = {32'h1, 32'hFFFFFFFF, 32'h40000000, 32'hC0000000};
    localparam [95:0] EV = {24'h1, 24'hFFFFFF, 24'h7FFFFF, 24'h800000};
    reg clock = 1'b0;
    reg srst = 1'b1;
    reg signed [31:0] filt_data = 32'h0;
    reg last_q = 1'b0;
    reg rdy;
    reg [47:0] rx;
    integer n_fail = 0;
    integer total_checks = 0;
    integer k;
    wire cs_n, sclk, din, pin, dout, oe, pull, pwr, act;
    wire [15:0] conv_cfg, cfg_word;
    wire [23:0] res;
    // ****************************************
    // clock, device and host
    // ****************************************
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) if (oe) last_q <= dout;
    // released pin: pull-up level, else the inverse of the last bit
    assign pin = oe ? dout : (pull ? 1'b1 : ~last_q);
    sac_conv_ctrl #(.WAKE_CYC(32'h14), .DRDY_LEAD_CYC(32'h4),
        .TIMEOUT_CYC(32'hC8), .CONV_BASE_CYC(32'h32), .FILT_W(32)) DUT (
        .clock(clock), .srst(srst), .cs_n(cs_n), .sclk(sclk), .din(din),
        .serial_out_ready_n(dout), .serial_out_oe(oe),
        .serial_out_pullup(pull), .filt_data(filt_data),
        .powered_up(pwr), .conv_active(act), .conv_cfg(conv_cfg),
        .result_data(res), .cfg_word(cfg_word));
    sac_host_model u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .pin(pin));
    // ****************************************
    // tasks and tests
    // ****************************************
    task check(input [47:0] got, input [47:0] exp, input [63:0] what);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr_cfg(input [15:0] cfg);
        reg r;
        begin
            u_host.sel(r);
            u_host.xfer(24, {32'h0, cfg}, rx);
            u_host.desel;
        end
    endtask
    task wait_idle;
        integer t;
        begin
            for (t = 0; t < 4000 && pwr !== 1'b0; t = t + 1)
                @(negedge clock);
            check(pwr, 1'b0, "power");
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        end_of_test;
    end
    initial begin
        repeat (4) @(negedge clock);
        srst = 1'b0;
        @(negedge clock);
        check({cfg_word, res}, {16'h858B, 24'h0}, "reset");
        check({pwr, oe, pull}, 3'b001, "pins");
        u_host.xfer(4, 48'hF, rx);
        check({oe, dout}, 2'b01, "desel");
        u_host.sel(rdy);
        check(rdy, 1'b1, "ready");
        u_host.xfer(48, 48'h0, rx);
        u_host.desel;
        check(rx, {32'h0, 16'h858B}, "read48");
        for (k = 0; k < 4; k = k + 1) begin
            filt_data = FV[32 * (3 - k) +: 32];
            wr_cfg(16'h858B);
            check({pwr, act, cfg_word[15]}, 3'b100, "wake");
            wr_cfg(16'h858B);
            wait_idle;
            check(res, EV[24 * (3 - k) +: 24], "result");
        end
        repeat (100) @(negedge clock);
        check({pwr, cfg_word[15]}, 2'b01, "idle");
        u_host.sel(rdy);
        check(rdy, 1'b0, "ready");
        u_host.xfer(32, 48'h0, rx);
        u_host.desel;
        check(rx[31:0], 32'h80000000, "read32");
        u_host.sel(rdy);
        u_host.desel;
        check(rdy, 1'b1, "ready");
        wr_cfg(16'h0589);
        check(cfg_word, 16'h858B, "cfg");
        wr_cfg(16'h0583);
        check({cfg_word, pull}, {16'h8583, 1'b0}, "pullup");
        filt_data = 32'h100;
        wr_cfg(16'h0483);
        wr_cfg(16'h04E3);
        check({act, conv_cfg[7:5], cfg_word}, {1'b1, 3'h4, 16'h04E3},
            "cfg_mid");
        repeat (400) @(negedge clock);
        filt_data = 32'h200;
        repeat (120) @(negedge clock);
        check({conv_cfg[7:5], res}, {3'h7, 24'h200}, "cont");
        u_host.sel(rdy);
        u_host.xfer(8, 48'h0, rx);
        #1200;
        fork
            u_host.xfer(24, 48'h0, rx);
            #300 filt_data = 32'h300;
        join
        u_host.desel;
        check({rx[23:0], res}, {24'h200, 24'h300}, "lock");
        wr_cfg(16'h0583);
        wait_idle;
        repeat (100) @(negedge clock);
        check(pwr, 1'b0, "single");
        u_host.sel(rdy);
        u_host.xfer(48, 48'h8100_0012_ACCA, rx);
        u_host.xfer(48, 48'h8100_0014_0003, rx);
        check(res, 24'h300, "noreset");
        u_host.xfer(48, 48'h8100_0012_ACCA, rx);
        u_host.xfer(48, 48'h8100_0014_0002, rx);
        #48;
        check({cfg_word, res}, {16'h858B, 24'h0}, "swreset");
        u_host.desel;
        // settle time after the reset words, shortened for the bench
        #2000;
        end_of_test;
    end
endmodule // sac_conv_ctrl_test
